// ### design/radio_task_event_map.svh
// register offsets, field positions and reset values of the radio task/event slice
`ifndef RADIO_TASK_EVENT_MAP_SVH
`define RADIO_TASK_EVENT_MAP_SVH

`define RTE_OFF_RX_ENABLE_TASK     12'h004
`define RTE_OFF_START_TASK         12'h008
`define RTE_OFF_STOP_TASK          12'h00C
`define RTE_OFF_DISABLE_TASK       12'h010
`define RTE_OFF_STRENGTH_START     12'h014
`define RTE_OFF_STRENGTH_STOP      12'h018
`define RTE_OFF_BITCNT_START       12'h01C
`define RTE_OFF_BITCNT_STOP        12'h020
`define RTE_OFF_ENERGY_START       12'h024
`define RTE_OFF_ENERGY_STOP        12'h028
`define RTE_OFF_CHANNEL_START      12'h02C
`define RTE_OFF_CHANNEL_STOP       12'h030
`define RTE_OFF_RAMPED_UP_EVENT    12'h100
`define RTE_OFF_ADDRESS_EVENT      12'h104
`define RTE_OFF_PAYLOAD_EVENT      12'h108
`define RTE_OFF_PACKET_EVENT       12'h10C
`define RTE_OFF_IRQ_STATUS         12'h300
`define RTE_OFF_IRQ_MASK           12'h304
`define RTE_OFF_RUN_STATUS         12'h308

`define RTE_TASK_BIT               0
`define RTE_EVENT_BIT              0
`define RTE_NUM_TASKS              12
`define RTE_NUM_EVENTS             4
`define RTE_NUM_RUN                5
`define RTE_ADDR_BITS              12
`define RTE_RESET_WORD             32'h0000_0000
`define RTE_RESET_EVENTS           4'h0
`define RTE_RESET_RUN              5'h00

`endif

// ### design/radio_task_event_pkg.sv
// types of the radio task/event slice
package radio_task_event_pkg;

   // one-cycle task strobes, index equals (offset - 4) / 4
   typedef enum logic [3:0] {
      TASK_RX_ENABLE = 4'h0,
      TASK_START     = 4'h1,
      TASK_STOP      = 4'h2,
      TASK_DISABLE   = 4'h3,
      TASK_SS_START  = 4'h4,
      TASK_SS_STOP   = 4'h5,
      TASK_BC_START  = 4'h6,
      TASK_BC_STOP   = 4'h7,
      TASK_ED_START  = 4'h8,
      TASK_ED_STOP   = 4'h9,
      TASK_CCA_START = 4'hA,
      TASK_CCA_STOP  = 4'hB
   } task_idx_t;

   // radio control state, one-hot
   typedef enum logic [3:0] {
      RADIO_DISABLED = 4'b0001,
      RADIO_RAMPUP   = 4'b0010,
      RADIO_IDLE     = 4'b0100,
      RADIO_ACTIVE   = 4'b1000
   } radio_state_t;

   // run-status bit positions
   typedef enum logic [2:0] {
      RUN_SAMPLING  = 3'h0,
      RUN_BITCOUNT  = 3'h1,
      RUN_ENERGY    = 3'h2,
      RUN_CHANNEL   = 3'h3,
      RUN_RX_MODE   = 3'h4
   } run_idx_t;

endpackage : radio_task_event_pkg

// ### design/radio_task_event_regs.sv
// APB task/event register slice of the radio control logic
//
// How it works
// - writing 1 to rx-enable task starts receive ramp-up; register stores nothing
// - signal-strength start task begins a one-sample measurement
// - signal-strength stop task halts any ongoing strength measurement
// - bit-counter start task sets the bit counter running
// - bit-counter stop task stops the bit counter
// - energy-detect start task begins an energy detection measurement
// - energy-detect stop task ends an energy detection in progress
// - channel-assessment start task begins a clear channel assessment
// - channel-assessment stop task ends a clear channel assessment in progress
// - ramped-up event set after ramp-up completes; software reads and writes it
// - address event set when a packet address passes
// - payload event set when a packet payload passes
// - packet event set when a whole packet passes
`include "radio_task_event_map.svh"
`timescale 1ns/1ps
`default_nettype none

module radio_task_event_regs #(
   parameter int unsigned RAMPUP_CYCLES = 8
) (
   // clock and reset
   input  wire logic                      sys_clk_i,
   input  wire logic                      sys_rst_i,
   // apb slave
   input  wire logic                      psel_i,
   input  wire logic                      penable_i,
   input  wire logic                      pwrite_i,
   input  wire logic [31:0]               paddr_i,
   input  wire logic [31:0]               pwdata_i,
   output logic      [31:0]               prdata_o,
   output logic                           pready_o,
   output logic                           pslverr_o,
   // radio datapath event strobes (same clock)
   input  wire logic                      addr_done_i,
   input  wire logic                      payload_done_i,
   input  wire logic                      packet_done_i,
   input  wire logic                      sample_done_i,
   // task strobes and run levels toward the radio datapath
   output logic [`RTE_NUM_TASKS-1:0]      task_pulse_o,
   output logic                           rx_mode_o,
   output logic                           transfer_o,
   output logic                           sampling_o,
   output logic                           bit_count_o,
   output logic                           energy_detect_o,
   output logic                           channel_assess_o,
   // interrupt
   output logic                           irq_o
);

   typedef radio_task_event_pkg::radio_state_t state_t;

   // address decode
   function automatic logic hit(input logic [31:0] a, input logic [`RTE_ADDR_BITS-1:0] off);
      hit = (a[`RTE_ADDR_BITS-1:0] == off) && (a[31:`RTE_ADDR_BITS] == '0);
   endfunction : hit

   wire logic access = psel_i && penable_i;
   wire logic wr     = access && pwrite_i;
   wire logic rd     = access && !pwrite_i;
   wire logic wbit   = pwdata_i[`RTE_TASK_BIT];

   logic [`RTE_NUM_TASKS-1:0] task_hit;
   genvar gi;
   generate
      for (gi = 0; gi < `RTE_NUM_TASKS; gi++) begin : g_task
         assign task_hit[gi] = hit(paddr_i, `RTE_ADDR_BITS'(`RTE_OFF_RX_ENABLE_TASK + 4 * gi));
      end
   endgenerate

   logic [`RTE_NUM_EVENTS-1:0] event_hit;
   generate
      for (gi = 0; gi < `RTE_NUM_EVENTS; gi++) begin : g_evhit
         assign event_hit[gi] = hit(paddr_i,
                                    `RTE_ADDR_BITS'(`RTE_OFF_RAMPED_UP_EVENT + 4 * gi));
      end
   endgenerate

   wire logic stat_hit = hit(paddr_i, `RTE_OFF_IRQ_STATUS);
   wire logic mask_hit = hit(paddr_i, `RTE_OFF_IRQ_MASK);
   wire logic run_hit  = hit(paddr_i, `RTE_OFF_RUN_STATUS);
   wire logic mapped   = (|task_hit) || (|event_hit) || stat_hit || mask_hit || run_hit;

   // task strobes: only a written 1 fires, a written 0 does nothing
   wire logic [`RTE_NUM_TASKS-1:0] fire = (wr && wbit) ? task_hit : '0;

   wire logic t_rxen   = fire[radio_task_event_pkg::TASK_RX_ENABLE];
   wire logic t_start  = fire[radio_task_event_pkg::TASK_START];
   wire logic t_stop   = fire[radio_task_event_pkg::TASK_STOP];
   wire logic t_dis    = fire[radio_task_event_pkg::TASK_DISABLE];
   wire logic t_ss_on  = fire[radio_task_event_pkg::TASK_SS_START];
   wire logic t_ss_off = fire[radio_task_event_pkg::TASK_SS_STOP];
   wire logic t_bc_on  = fire[radio_task_event_pkg::TASK_BC_START];
   wire logic t_bc_off = fire[radio_task_event_pkg::TASK_BC_STOP];
   wire logic t_ed_on  = fire[radio_task_event_pkg::TASK_ED_START];
   wire logic t_ed_off = fire[radio_task_event_pkg::TASK_ED_STOP];
   wire logic t_cc_on  = fire[radio_task_event_pkg::TASK_CCA_START];
   wire logic t_cc_off = fire[radio_task_event_pkg::TASK_CCA_STOP];

   // radio control state machine
   state_t state_q;
   state_t state_d;
   logic [15:0] ramp_cnt_q;
   logic [15:0] ramp_cnt_d;
   logic        ramp_done;
   logic        rx_mode_q;

   assign ramp_done = (state_q == radio_task_event_pkg::RADIO_RAMPUP)
                      && (ramp_cnt_q == 16'(RAMPUP_CYCLES - 1));

   always_comb begin
      state_d    = state_q;
      ramp_cnt_d = '0;
      unique case (state_q)
         radio_task_event_pkg::RADIO_DISABLED: begin
            if (t_rxen) begin
               state_d = radio_task_event_pkg::RADIO_RAMPUP;
            end
         end
         radio_task_event_pkg::RADIO_RAMPUP: begin
            ramp_cnt_d = ramp_cnt_q + 16'h0001;
            if (t_dis) begin
               state_d = radio_task_event_pkg::RADIO_DISABLED;
            end else if (ramp_done) begin
               state_d = radio_task_event_pkg::RADIO_IDLE;
            end
         end
         radio_task_event_pkg::RADIO_IDLE: begin
            if (t_dis) begin
               state_d = radio_task_event_pkg::RADIO_DISABLED;
            end else if (t_start) begin
               state_d = radio_task_event_pkg::RADIO_ACTIVE;
            end
         end
         radio_task_event_pkg::RADIO_ACTIVE: begin
            if (t_dis) begin
               state_d = radio_task_event_pkg::RADIO_DISABLED;
            end else if (t_stop) begin
               state_d = radio_task_event_pkg::RADIO_IDLE;
            end
         end
         default: begin
            state_d = radio_task_event_pkg::RADIO_DISABLED;
         end
      endcase
   end

   // state register
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         state_q <= radio_task_event_pkg::RADIO_DISABLED;
      end else begin
         state_q <= state_d;
      end
   end

   // ramp counter rests at zero outside ramp-up, so every ramp runs full length
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         ramp_cnt_q <= '0;
      end else begin
         ramp_cnt_q <= ramp_cnt_d;
      end
   end

   // receive mode latches only from disabled; a repeated rx-enable is ignored
   wire logic rx_set = t_rxen && (state_q == radio_task_event_pkg::RADIO_DISABLED);

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         rx_mode_q <= 1'b0;
      end else if (rx_set) begin
         rx_mode_q <= 1'b1;
      end else if (t_dis) begin
         rx_mode_q <= 1'b0;
      end
   end

   // measurement run flags; stop beats start when both land together
   logic [`RTE_NUM_RUN-1:0] run_q;
   logic [`RTE_NUM_RUN-1:0] run_d;
   wire logic [3:0] run_on  = {t_cc_on, t_ed_on, t_bc_on, t_ss_on};
   wire logic [3:0] run_off = {t_cc_off, t_ed_off, t_bc_off, t_ss_off | sample_done_i};

   generate
      for (gi = 0; gi < 4; gi++) begin : g_run
         assign run_d[gi] = run_off[gi] ? 1'b0 : (run_on[gi] ? 1'b1 : run_q[gi]);
      end
   endgenerate
   assign run_d[radio_task_event_pkg::RUN_RX_MODE] = rx_mode_q;

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         run_q <= `RTE_RESET_RUN;
      end else begin
         run_q <= run_d;
      end
   end

   // event registers: hardware set wins over a software write of 0
   wire logic [`RTE_NUM_EVENTS-1:0] ev_set =
      {packet_done_i, payload_done_i, addr_done_i, ramp_done};
   logic [`RTE_NUM_EVENTS-1:0] event_q;
   logic [`RTE_NUM_EVENTS-1:0] event_d;
   logic [`RTE_NUM_EVENTS-1:0] irq_stat_q;
   logic [`RTE_NUM_EVENTS-1:0] irq_stat_d;
   logic [`RTE_NUM_EVENTS-1:0] irq_mask_q;

   generate
      for (gi = 0; gi < `RTE_NUM_EVENTS; gi++) begin : g_ev
         assign event_d[gi] = ev_set[gi] ? 1'b1 :
                              ((wr && event_hit[gi]) ? pwdata_i[`RTE_EVENT_BIT] : event_q[gi]);
      end
   endgenerate

   // interrupt status cleared by its own read, set still wins
   assign irq_stat_d = ev_set | ((rd && stat_hit) ? '0 : irq_stat_q);

   // event flags
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         event_q <= `RTE_RESET_EVENTS;
      end else begin
         event_q <= event_d;
      end
   end

   // interrupt status
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         irq_stat_q <= `RTE_RESET_EVENTS;
      end else begin
         irq_stat_q <= irq_stat_d;
      end
   end

   // mask holds its value between writes
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         irq_mask_q <= `RTE_RESET_EVENTS;
      end else if (wr && mask_hit) begin
         irq_mask_q <= pwdata_i[`RTE_NUM_EVENTS-1:0];
      end
   end

   // read mux; task offsets read 0
   logic [31:0] rdata_d;
   always_comb begin
      rdata_d = `RTE_RESET_WORD;
      for (int i = 0; i < `RTE_NUM_EVENTS; i++) begin
         if (event_hit[i]) begin
            rdata_d = {31'h0000_0000, event_q[i]};
         end
      end
      if (stat_hit) begin
         rdata_d = {28'h000_0000, irq_stat_q};
      end
      if (mask_hit) begin
         rdata_d = {28'h000_0000, irq_mask_q};
      end
      if (run_hit) begin
         rdata_d = {27'h000_0000, run_q};
      end
   end

   // apb answers in the access phase's first cycle, zero wait
   logic [31:0]               prdata_q;
   logic                      pready_q;
   logic                      pslverr_q;
   logic [`RTE_NUM_TASKS-1:0] pulse_q;
   logic                      irq_q;

   // decode taken in the setup cycle so the answer stands on the first access edge
   wire logic        setup      = psel_i && !penable_i;
   wire logic        setup_read = setup && !pwrite_i;
   wire logic        setup_bad  = setup && !mapped;
   wire logic        irq_level  = |(irq_stat_d & irq_mask_q);
   wire logic [31:0] rdata_nx   = setup_read ? rdata_d : `RTE_RESET_WORD;

   // ready strobe, one cycle
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         pready_q <= 1'b0;
      end else begin
         pready_q <= setup;
      end
   end

   // error strobe for unmapped addresses, alongside ready
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         pslverr_q <= 1'b0;
      end else begin
         pslverr_q <= setup_bad;
      end
   end

   // read data; zero outside the access cycle so stale data never leaks
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         prdata_q <= `RTE_RESET_WORD;
      end else begin
         prdata_q <= rdata_nx;
      end
   end

   // task strobes, raised on the write edge and held for one cycle
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         pulse_q <= '0;
      end else begin
         pulse_q <= fire;
      end
   end

   // interrupt level; next status used so a set and a clear never glitch it
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= irq_level;
      end
   end

   assign prdata_o         = prdata_q;
   assign pready_o         = pready_q;
   assign pslverr_o        = pslverr_q;
   assign task_pulse_o     = pulse_q;
   assign irq_o            = irq_q;
   assign rx_mode_o        = rx_mode_q;
   assign transfer_o       = state_q[3];
   assign sampling_o       = run_q[radio_task_event_pkg::RUN_SAMPLING];
   assign bit_count_o      = run_q[radio_task_event_pkg::RUN_BITCOUNT];
   assign energy_detect_o  = run_q[radio_task_event_pkg::RUN_ENERGY];
   assign channel_assess_o = run_q[radio_task_event_pkg::RUN_CHANNEL];

endmodule : radio_task_event_regs

`default_nettype wire

// ### verif/radio_task_event_regs_asserts.sv
// port assertions of the radio task/event register slice
`timescale 1ns/1ps
`default_nettype none
module radio_task_event_regs_asserts #(
   parameter int unsigned RAMPUP_CYCLES = 8
) (
   // clock, reset, apb
   input wire logic        sys_clk_i,
   input wire logic        sys_rst_i,
   input wire logic        psel_i,
   input wire logic        penable_i,
   input wire logic        pwrite_i,
   input wire logic [31:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [31:0] prdata_o,
   input wire logic        pready_o,
   input wire logic        pslverr_o,
   // datapath side
   input wire logic        addr_done_i,
   input wire logic        payload_done_i,
   input wire logic        packet_done_i,
   input wire logic        sample_done_i,
   input wire logic [11:0] task_pulse_o,
   input wire logic        rx_mode_o,
   input wire logic        transfer_o,
   input wire logic        sampling_o,
   input wire logic        bit_count_o,
   input wire logic        energy_detect_o,
   input wire logic        channel_assess_o,
   input wire logic        irq_o
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);
   wire logic acc_w = psel_i && penable_i && pready_o && pwrite_i;
   wire logic acc_r = psel_i && penable_i && pready_o && !pwrite_i;
   wire logic set_w = acc_w && pwdata_i[0];
   sequence apb_setup;
      psel_i && !penable_i;
   endsequence
   sequence apb_answer;
      psel_i && penable_i && pready_o;
   endsequence
   zero_wait_a: assert property (apb_setup |=> apb_answer) else $error("pready late");
   rx_enable_a: assert property (set_w && paddr_i == 32'h004 |=> task_pulse_o[0] && rx_mode_o)
      else $error("rx enable lost");
   zero_write_a: assert property (acc_w && !pwdata_i[0] |=> task_pulse_o == 12'h000)
      else $error("zero write fired");
   task_read_a: assert property (acc_r && paddr_i >= 32'h004 && paddr_i <= 32'h030
      |-> prdata_o == 32'h0) else $error("task read nonzero");
   one_sample_a: assert property (sampling_o && sample_done_i && !acc_w |=> !sampling_o)
      else $error("sampling kept");
   sample_stop_a: assert property (set_w && paddr_i == 32'h018 |=> !sampling_o)
      else $error("sampling not stopped");
   bc_start_a: assert property (set_w && paddr_i == 32'h01C |=> bit_count_o)
      else $error("bit count not started");
   bc_stop_a: assert property (set_w && paddr_i == 32'h020 |=> !bit_count_o)
      else $error("bit count not stopped");
   ed_start_a: assert property (set_w && paddr_i == 32'h024 |=> energy_detect_o)
      else $error("energy detect not started");
   cca_stop_a: assert property (set_w && paddr_i == 32'h030 |=> !channel_assess_o)
      else $error("assessment not stopped");
   disable_a: assert property (set_w && paddr_i == 32'h010 |=> !rx_mode_o && !transfer_o)
      else $error("disable ignored");
endmodule : radio_task_event_regs_asserts
`default_nettype wire

// ### verif/testbench.sv
// self-checking bench of the radio task/event register slice
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic        sys_clk_i, sys_rst_i, psel, penable, pwrite, er;
   logic [31:0] paddr, pwdata, prdata, rd;
   logic        pready, pslverr, irq, rx_mode, xfer, smp, bcnt, ed, cca;
   logic [3:0]  ev;
   logic [11:0] pulse;
   int          mismatches, n_compared, cycles;
   always #2.5 sys_clk_i = ~sys_clk_i;
   radio_task_event_regs #(.RAMPUP_CYCLES(2)) uut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
      .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
      .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
      .addr_done_i(ev[0]), .payload_done_i(ev[1]), .packet_done_i(ev[2]),
      .sample_done_i(ev[3]), .task_pulse_o(pulse), .rx_mode_o(rx_mode), .transfer_o(xfer),
      .sampling_o(smp), .bit_count_o(bcnt), .energy_detect_o(ed), .channel_assess_o(cca),
      .irq_o(irq));
   task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask : cmp
   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge sys_clk_i);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge sys_clk_i);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk_i);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         mismatches++;
         $display("CHECK FAILED pready expected 1 seen %b", pready);
      end
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      cmp("prdata", exp, rd);
   endtask : rchk
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
      @(negedge sys_clk_i);
   endtask : wr
   // one-cycle strobe on datapath input i, then let status reach irq
   task automatic fire(input int i);
      @(posedge sys_clk_i);
      ev <= 4'h1 << i;
      @(posedge sys_clk_i);
      ev <= 4'h0;
      repeat (2) @(negedge sys_clk_i);
   endtask : fire
   task automatic tally_and_finish;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : tally_and_finish
   always @(posedge sys_clk_i) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         tally_and_finish();
      end
   end
   initial begin
      {sys_clk_i, psel, penable, pwrite, paddr, pwdata, ev} = '0;
      {mismatches, n_compared, cycles} = '0;
      sys_rst_i = 1'b1;
      repeat (20) @(posedge sys_clk_i);
      sys_rst_i <= 1'b0;
      for (int i = 0; i < 4; i++) rchk(32'h100 + 4 * i, 32'h0);
      for (int i = 0; i < 12; i++) rchk(32'h004 + 4 * i, 32'h0);
      rchk(32'h308, 32'h0);
      apb(1'b0, 32'h0000_0200, 32'h0);
      cmp("pslverr", 32'h1, {31'h0, er});
      wr(32'h004, 32'h0);
      cmp("rx_mode", 32'h0, {31'h0, rx_mode});
      wr(32'h004, 32'h1);
      cmp("task_pulse", 32'h1, {20'h0, pulse});
      cmp("rx_mode", 32'h1, {31'h0, rx_mode});
      rd = 32'h0;
      for (int i = 0; i < 20 && rd !== 32'h1; i++) apb(1'b0, 32'h100, 32'h0);
      cmp("ramped_up", 32'h1, rd);
      wr(32'h100, 32'h0);
      rchk(32'h100, 32'h0);
      wr(32'h008, 32'h1);
      cmp("transfer", 32'h1, {31'h0, xfer});
      wr(32'h00C, 32'h1);
      cmp("transfer", 32'h0, {31'h0, xfer});
      wr(32'h008, 32'h1);
      wr(32'h010, 32'h1);
      cmp("rx_and_transfer", 32'h0, {30'h0, xfer, rx_mode});
      for (int i = 0; i < 4; i++) begin
         wr(32'h014 + 8 * i, 32'h1);
         cmp("run_pins", 32'h1 << i, {28'h0, cca, ed, bcnt, smp});
         rchk(32'h308, 32'h1 << i);
         wr(32'h018 + 8 * i, 32'h1);
         rchk(32'h308, 32'h0);
      end
      wr(32'h014, 32'h1);
      fire(3);
      cmp("sampling", 32'h0, {31'h0, smp});
      rchk(32'h300, 32'h1);
      wr(32'h304, 32'hF);
      for (int i = 0; i < 3; i++) begin
         fire(i);
         cmp("irq", 32'h1, {31'h0, irq});
         rchk(32'h104 + 4 * i, 32'h1);
         rchk(32'h300, 32'h2 << i);
         wr(32'h104 + 4 * i, 32'h0);
         cmp("irq", 32'h0, {31'h0, irq});
         rchk(32'h104 + 4 * i, 32'h0);
      end
      wr(32'h304, 32'h0);
      fire(0);
      cmp("irq_masked", 32'h0, {31'h0, irq});
      rchk(32'h300, 32'h2);
      tally_and_finish();
   end
endmodule : testbench
bind radio_task_event_regs radio_task_event_regs_asserts #(.RAMPUP_CYCLES(RAMPUP_CYCLES)) chk (
   .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i), .penable_i(penable_i),
   .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
   .pready_o(pready_o), .pslverr_o(pslverr_o), .addr_done_i(addr_done_i),
   .payload_done_i(payload_done_i), .packet_done_i(packet_done_i),
   .sample_done_i(sample_done_i), .task_pulse_o(task_pulse_o), .rx_mode_o(rx_mode_o),
   .transfer_o(transfer_o), .sampling_o(sampling_o), .bit_count_o(bit_count_o),
   .energy_detect_o(energy_detect_o), .channel_assess_o(channel_assess_o), .irq_o(irq_o));
`default_nettype wire
